// ---- brs_pkg.sv ----
// Constants and types shared by the reclose sequencer
package brs_pkg;

	// ==================================================================
	// Clock and timing
	localparam longint unsigned CLK_HZ         = 64'd50_000_000;
	localparam longint unsigned CYC_PER_MS     = CLK_HZ / 64'd1000;
	localparam longint unsigned DEAD_FAST_MS   = 64'd200;
	localparam longint unsigned DEAD_SLOW_MS   = 64'd60_000;
	localparam longint unsigned SHOT_RECL_MS   = 64'd10_000;
	localparam longint unsigned SEQ_RECL_MS    = 64'd10_000;
	localparam longint unsigned DEAD_FAST_CYCL = DEAD_FAST_MS * CYC_PER_MS;
	localparam longint unsigned DEAD_SLOW_CYCL = DEAD_SLOW_MS * CYC_PER_MS;
	localparam longint unsigned SHOT_RECL_CYCL = SHOT_RECL_MS * CYC_PER_MS;
	localparam longint unsigned SEQ_RECL_CYCL  = SEQ_RECL_MS * CYC_PER_MS;

	// ==================================================================
	// Sizes
	localparam int NUM_REQ  = 5;
	localparam int NUM_SHOT = 2;
	localparam int NUM_DEAD = NUM_REQ * NUM_SHOT;

	// ==================================================================
	// Register offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_SHOTEN = 8'h04;
	localparam logic [7:0] A_SHREC  = 8'h08;
	localparam logic [7:0] A_SQREC  = 8'h0C;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_IRQST  = 8'h14;
	localparam logic [7:0] A_IRQMSK = 8'h18;
	localparam logic [7:0] A_DEAD0  = 8'h20;
	localparam logic [7:0] A_DEADN  = 8'h44;

	// ==================================================================
	// Field positions and reset values
	localparam int CTRL_EN    = 0;
	localparam int CTRL_FINSQ = 1;
	localparam logic [1:0] CTRL_RST   = 2'h3;
	localparam logic [9:0] SHOTEN_RST = 10'h3FF;
	localparam int EV_START = 0;
	localparam int EV_ADV   = 1;
	localparam int EV_FINAL = 2;
	localparam int EV_LOCK  = 3;
	localparam int EV_FAIL  = 4;
	localparam int EV_READY = 5;
	localparam int NUM_EV   = 6;

	// ==================================================================
	// Sequencer states
	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_WOPEN = 8'h02,
		S_DEAD  = 8'h04,
		S_CLOSE = 8'h08,
		S_RECL  = 8'h10,
		S_SEQR  = 8'h20,
		S_FINAL = 8'h40,
		S_LOCK  = 8'h80
	} brs_state_e;

	// Pins from protection stages and breaker object
	typedef struct packed {
		logic [NUM_REQ-1:0] trip;
		logic               crit;
		logic               brkOpen;
		logic               brkClosed;
		logic               ackOk;
		logic               ackFail;
		logic               extRst;
	} brs_pins_s;

endpackage : brs_pkg

// ---- brs_sequencer.sv ----
// Breaker reclose sequencer with register port and interrupt
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
module brs_sequencer
	import brs_pkg::*;
#(
	parameter logic [31:0] DEAD_FAST_CYC = 32'(DEAD_FAST_CYCL),
	parameter logic [31:0] DEAD_SLOW_CYC = 32'(DEAD_SLOW_CYCL),
	parameter logic [31:0] SHOT_RECL_CYC = 32'(SHOT_RECL_CYCL),
	parameter logic [31:0] SEQ_RECL_CYC  = 32'(SEQ_RECL_CYCL)
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	// Register port
	input  wire logic [7:0]          regAddr,
	input  wire logic [31:0]         regWrData,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output logic      [31:0]         regRdData,
	// Protection requests
	input  wire logic [NUM_REQ-1:0]  reqTrip,
	input  wire logic                critReq,
	// Breaker object
	input  wire logic                brkOpen,
	input  wire logic                brkClosed,
	input  wire logic                objAckOk,
	input  wire logic                objAckFail,
	input  wire logic                lockResetIn,
	output logic                     closeCmd,
	output logic                     openCmd,
	// Sequence indications
	output logic                     sequenceActive,
	output logic [NUM_REQ-1:0]       requestPending,
	output logic [NUM_SHOT-1:0]      shotActive,
	output logic                     sequenceReclaimActive,
	output logic                     lockOutState,
	output logic                     irq
);

	// Assertion clock and reset for the whole module
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// ==================================================================
	// State
	typedef struct packed {
		brs_pins_s                s1;
		brs_pins_s                s2;
		brs_pins_s                s3;
		brs_state_e               st;
		logic [2:0]               req;
		logic                     shot;
		logic [31:0]              tmr;
		logic [1:0]               ctrl;
		logic [NUM_DEAD-1:0]      shotEn;
		logic [31:0]              shRec;
		logic [31:0]              sqRec;
		logic [NUM_DEAD-1:0][31:0] dead;
		logic [NUM_EV-1:0]        irqSt;
		logic [NUM_EV-1:0]        irqMsk;
		logic [31:0]              rdData;
		logic                     closeCmd;
		logic                     openCmd;
		logic                     seqAct;
		logic [NUM_REQ-1:0]       reqPend;
		logic [NUM_SHOT-1:0]      shotAct;
		logic                     seqRecAct;
		logic                     lockOut;
		logic                     irq;
	} brs_regs_s;

	brs_regs_s          q;
	brs_regs_s          next_q;
	brs_pins_s          pinsIn;
	brs_pins_s          p;
	logic [NUM_EV-1:0]  ev;
	logic               hit;
	logic [2:0]         pick;
	logic               tmrDone;
	logic               closedRise;
	logic               doStart;
	logic               goFinal;
	logic               goLock;
	logic [NUM_EV-1:0]  w1c;

	// ==================================================================
	// Functions
	// Highest priority tripping request, first one wins
	function automatic logic [2:0] firstReq(input logic [NUM_REQ-1:0] t);
		firstReq = 3'h0;
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (t[i]) begin
				firstReq = 3'(i);
			end
		end
	endfunction : firstReq

	// Enable bit of a shot in a request's shot list
	function automatic logic shotOn(input logic [NUM_DEAD-1:0] en,
		input logic [2:0] r, input logic s);
		shotOn = en[4'(r) * 4'(NUM_SHOT) + 4'(s)];
	endfunction : shotOn

	// Dead time register index of a request and shot
	function automatic logic [3:0] deadIdx(input logic [2:0] r,
		input logic s);
		deadIdx = 4'(r) * 4'(NUM_SHOT) + 4'(s);
	endfunction : deadIdx

	// One-hot mask of a request
	function automatic logic [NUM_REQ-1:0] reqMask(input logic [2:0] r);
		reqMask = NUM_REQ'(1) << r;
	endfunction : reqMask

	// ==================================================================
	// Pin bundle
	assign pinsIn = '{trip: reqTrip, crit: critReq, brkOpen: brkOpen,
		brkClosed: brkClosed, ackOk: objAckOk, ackFail: objAckFail,
		extRst: lockResetIn};
	assign p = q.s2;

	// ==================================================================
	// Next state
	always_comb begin
		next_q = q;
		ev = '0;
		doStart = 1'b0;
		goFinal = 1'b0;
		goLock = 1'b0;
		w1c = '0;
		// Two-stage pin synchroniser, third stage for edges
		next_q.s1 = pinsIn;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		closedRise = p.brkClosed & ~q.s3.brkClosed;
		hit = |p.trip;
		pick = firstReq(p.trip);
		tmrDone = (q.tmr == 32'h0000_0000);
		next_q.tmr = tmrDone ? 32'h0000_0000 : q.tmr - 32'h0000_0001;

		// Sequencer
		case (q.st)
			S_IDLE: begin
				if (q.ctrl[CTRL_EN] && hit) begin
					doStart = 1'b1;
				end
			end
			S_WOPEN: begin
				if (p.ackFail) begin
					goLock = 1'b1;
					ev[EV_FAIL] = 1'b1;
				end else if (p.brkOpen && !p.trip[q.req]) begin
					// dead time after open and release
					next_q.st = S_DEAD;
					next_q.tmr = q.dead[deadIdx(q.req, q.shot)];
				end
			end
			S_DEAD: begin
				if (tmrDone) begin
					next_q.st = S_CLOSE;
				end
			end
			S_CLOSE: begin
				if (p.ackFail) begin
					goLock = 1'b1;
					ev[EV_FAIL] = 1'b1;
				end else if (p.brkClosed) begin
					next_q.st = S_RECL;
					next_q.tmr = q.shRec;
				end
			end
			S_RECL: begin
				if (hit) begin
					if (!q.shot && shotOn(q.shotEn, pick, 1'b1)) begin
						next_q.st = S_WOPEN;
						next_q.req = pick;
						next_q.shot = 1'b1;
						next_q.reqPend = reqMask(pick);
						next_q.shotAct = 2'b10;
						ev[EV_ADV] = 1'b1;
					end else begin
						goFinal = 1'b1;
					end
				end else if (tmrDone) begin
					next_q.seqAct = 1'b0;
					next_q.reqPend = '0;
					next_q.shotAct = '0;
					next_q.tmr = q.sqRec;
					if (q.sqRec == 32'h0000_0000) begin
						next_q.st = S_IDLE;
						ev[EV_READY] = 1'b1;
					end else begin
						next_q.st = S_SEQR;
					end
				end
			end
			S_SEQR: begin
				if (hit) begin
					if (q.ctrl[CTRL_FINSQ]) begin
						goFinal = 1'b1;
					end else begin
						doStart = q.ctrl[CTRL_EN];
					end
				end else if (tmrDone) begin
					next_q.st = S_IDLE;
					ev[EV_READY] = 1'b1;
				end
			end
			S_FINAL: begin
				if (p.ackFail) begin
					ev[EV_FAIL] = 1'b1;
				end
				if (p.ackFail || p.ackOk || p.brkOpen) begin
					goLock = 1'b1;
				end
			end
			S_LOCK: begin
				// leave by reset input or close
				if (p.extRst || closedRise) begin
					next_q.st = S_IDLE;
				end
			end
			default: begin
				next_q.st = S_IDLE;
			end
		endcase

		// first trip sets all three flags when a shot of the request is enabled
		// shot list of the chosen request
		if (doStart) begin
			next_q.req = pick;
			next_q.seqAct = 1'b1;
			next_q.reqPend = reqMask(pick);
			ev[EV_START] = 1'b1;
			if (shotOn(q.shotEn, pick, 1'b0)) begin
				next_q.st = S_WOPEN;
				next_q.shot = 1'b0;
				next_q.shotAct = 2'b01;
			end else if (shotOn(q.shotEn, pick, 1'b1)) begin
				next_q.st = S_WOPEN;
				next_q.shot = 1'b1;
				next_q.shotAct = 2'b10;
			end else begin
				goFinal = 1'b1;
			end
		end

		if (p.crit && q.st != S_LOCK && q.st != S_FINAL) begin
			goFinal = 1'b1;
			goLock = 1'b0;
		end

		if (goFinal) begin
			next_q.st = S_FINAL;
			ev[EV_FINAL] = 1'b1;
		end
		if (goLock) begin
			next_q.st = S_LOCK;
			ev[EV_LOCK] = 1'b1;
		end
		if (goFinal || goLock) begin
			next_q.seqAct = 1'b0;
			next_q.reqPend = '0;
			next_q.shotAct = '0;
		end

		// Outputs follow the state being entered
		next_q.closeCmd = (next_q.st == S_CLOSE);
		next_q.openCmd = (next_q.st == S_FINAL);
		next_q.seqRecAct = (next_q.st == S_SEQR);
		next_q.lockOut = (next_q.st == S_LOCK);

		// Register writes
		if (regWr) begin
			case (regAddr)
				A_CTRL: next_q.ctrl = regWrData[1:0];
				A_SHOTEN: next_q.shotEn = regWrData[NUM_DEAD-1:0];
				A_SHREC: next_q.shRec = regWrData;
				A_SQREC: next_q.sqRec = regWrData;
				A_IRQST: w1c = regWrData[NUM_EV-1:0];
				A_IRQMSK: next_q.irqMsk = regWrData[NUM_EV-1:0];
				default: begin
					if (regAddr >= A_DEAD0 && regAddr <= A_DEADN &&
						regAddr[1:0] == 2'b00) begin
						next_q.dead[4'((regAddr - A_DEAD0) >> 2)] =
							regWrData;
					end
				end
			endcase
		end
		// Sticky events, a new event wins over the clear
		next_q.irqSt = (q.irqSt & ~w1c) | ev;
		next_q.irq = |(next_q.irqSt & next_q.irqMsk);

		// Register reads, data in the following cycle only
		next_q.rdData = 32'h0000_0000;
		if (regRd) begin
			case (regAddr)
				A_CTRL: next_q.rdData = 32'(q.ctrl);
				A_SHOTEN: next_q.rdData = 32'(q.shotEn);
				A_SHREC: next_q.rdData = q.shRec;
				A_SQREC: next_q.rdData = q.sqRec;
				A_STATUS: next_q.rdData = 32'({q.lockOut, q.seqRecAct,
					q.seqAct, q.shotAct, q.reqPend, q.st});
				A_IRQST: next_q.rdData = 32'(q.irqSt);
				A_IRQMSK: next_q.rdData = 32'(q.irqMsk);
				default: begin
					if (regAddr >= A_DEAD0 && regAddr <= A_DEADN &&
						regAddr[1:0] == 2'b00) begin
						next_q.rdData = q.dead[4'((regAddr - A_DEAD0) >> 2)];
					end
				end
			endcase
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.st <= S_IDLE;
			q.ctrl <= CTRL_RST;
			q.shotEn <= SHOTEN_RST;
			q.shRec <= SHOT_RECL_CYC;
			q.sqRec <= SEQ_RECL_CYC;
			for (int i = 0; i < NUM_DEAD; i++) begin
				q.dead[i] <= (i % NUM_SHOT == 0) ? DEAD_FAST_CYC
					: DEAD_SLOW_CYC;
			end
		end else begin
			q <= next_q;
		end
	end

	// Outputs
	assign regRdData = q.rdData;
	assign closeCmd = q.closeCmd;
	assign openCmd = q.openCmd;
	assign sequenceActive = q.seqAct;
	assign requestPending = q.reqPend;
	assign shotActive = q.shotAct;
	assign sequenceReclaimActive = q.seqRecAct;
	assign lockOutState = q.lockOut;
	assign irq = q.irq;

	// ==================================================================
	// Assertions

	a_fail_lockout: assert property (
		(q.st == S_CLOSE || q.st == S_WOPEN) && p.ackFail && !p.crit
		|=> q.st == S_LOCK && lockOutState && !sequenceActive)
		else $error("object failure did not lock out");
	a_lock_holds: assert property (
		q.st == S_LOCK && !p.extRst && !closedRise
		|=> q.st == S_LOCK && lockOutState && !closeCmd)
		else $error("lock-out left without cause");
	a_first_trip: assert property (
		q.st == S_IDLE && q.ctrl[CTRL_EN] && hit && !p.crit
		&& shotOn(q.shotEn, pick, 1'b0)
		|=> sequenceActive && shotActive == 2'b01
		&& requestPending == reqMask($past(pick)))
		else $error("first trip flags wrong");
	a_dead_close: assert property (
		q.st == S_DEAD && tmrDone && !p.crit |=> closeCmd)
		else $error("no close after dead time");
	a_close_drop: assert property (
		q.st == S_CLOSE && p.brkClosed && !p.ackFail && !p.crit
		|=> !closeCmd && q.st == S_RECL && q.tmr == q.shRec)
		else $error("close not dropped into reclaim");
	a_shot_adv: assert property (
		q.st == S_RECL && hit && !p.crit && !q.shot
		&& shotOn(q.shotEn, pick, 1'b1)
		|=> shotActive == 2'b10 && q.st == S_WOPEN
		&& requestPending == reqMask($past(pick)))
		else $error("shot did not advance");
	a_last_final: assert property (
		q.st == S_RECL && hit && q.shot
		|=> openCmd && !sequenceActive && requestPending == '0
		&& shotActive == '0)
		else $error("final trip flags wrong");
	a_recl_done: assert property (
		q.st == S_RECL && tmrDone && !hit && !p.crit
		|=> !sequenceActive && requestPending == '0
		&& (sequenceReclaimActive || q.st == S_IDLE))
		else $error("reclaim expiry wrong");
	a_seq_final: assert property (
		q.st == S_SEQR && hit && q.ctrl[CTRL_FINSQ]
		|=> openCmd ##1 (openCmd || lockOutState))
		else $error("fault in sequence reclaim not final");
	a_crit_halt: assert property (
		p.crit && q.st != S_LOCK && q.st != S_FINAL |=> q.st == S_FINAL)
		else $error("critical request ignored");

	c_shot_adv: cover property (q.st == S_RECL ##1 shotActive == 2'b10);
	c_lockout: cover property (q.st == S_FINAL ##1 q.st == S_LOCK);
	c_ready: cover property (q.st == S_SEQR ##1 q.st == S_IDLE);
	c_fail: cover property (q.st == S_CLOSE && p.ackFail);

endmodule : brs_sequencer

// ---- brs_breaker_model.sv ----
// Behavioural breaker object answering the reclose sequencer
`timescale 1ns/1ps
module brs_breaker_model #(
	parameter int DELAY = 4
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// Commands from sequencer and protection
	input  wire logic closeCmd,
	input  wire logic openCmd,
	input  wire logic protOpen,
	// Test controls
	input  wire logic refuse,
	input  wire logic manualClose,
	// Breaker feedback
	output logic      brkOpen,
	output logic      brkClosed,
	output logic      objAckOk,
	output logic      objAckFail
);
	int   cnt;
	logic toOpen;
	logic toClose;

	// ==================================================================
	// Movement requests
	assign toOpen  = brkClosed && (openCmd || protOpen);
	assign toClose = brkOpen && closeCmd;

	// Travel timer, position and acknowledge pulses
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			brkOpen    <= 1'b0;
			brkClosed  <= 1'b1;
			objAckOk   <= 1'b0;
			objAckFail <= 1'b0;
			cnt        <= 0;
		end else begin
			objAckOk   <= 1'b0;
			objAckFail <= 1'b0;
			if (manualClose) begin
				brkOpen   <= 1'b0;
				brkClosed <= 1'b1;
				cnt       <= 0;
			end else if (!(toOpen || toClose)) begin
				cnt <= 0;
			end else if (cnt < DELAY) begin
				cnt <= cnt + 1;
			end else if (refuse && (openCmd || closeCmd)) begin
				objAckFail <= 1'b1;
				cnt        <= 0;
			end else begin
				brkOpen   <= toOpen;
				brkClosed <= toClose;
				objAckOk  <= 1'b1;
				cnt       <= 0;
			end
		end
	end
endmodule : brs_breaker_model

// ---- tb_top.sv ----
// Self-checking testbench for the breaker reclose sequencer
`timescale 1ns/1ps
module tb_top
	import brs_pkg::*;
;
	localparam int T_FAST = 20;
	localparam int T_SLOW = 40;
	localparam int T_SHR  = 30;
	localparam int T_SQR  = 30;
	localparam int T_ALT  = 10;
	localparam int W_CLS = 0, W_OPN = 1, W_LCK = 2, W_SEQ = 3;
	localparam int W_BOP = 4, W_BCL = 5, W_SRA = 6;

	logic        sys_clk, rstn, regWr, regRd, critReq, lockResetIn;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData, rd;
	logic [4:0]  reqTrip, requestPending;
	logic [1:0]  shotActive;
	logic        brkOpen, brkClosed, objAckOk, objAckFail, closeCmd, openCmd;
	logic        sequenceActive, sequenceReclaimActive, lockOutState, irq;
	logic        refuse, manualClose;
	int          fail_count, checks_done, n;

	// ==================================================================
	// Design and breaker object
	brs_sequencer #(
		.DEAD_FAST_CYC(32'(T_FAST)),
		.DEAD_SLOW_CYC(32'(T_SLOW)),
		.SHOT_RECL_CYC(32'(T_SHR)),
		.SEQ_RECL_CYC (32'(T_SQR))
	) i_dut (
		.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .reqTrip(reqTrip), .critReq(critReq),
		.brkOpen(brkOpen), .brkClosed(brkClosed), .objAckOk(objAckOk),
		.objAckFail(objAckFail), .lockResetIn(lockResetIn),
		.closeCmd(closeCmd), .openCmd(openCmd),
		.sequenceActive(sequenceActive), .requestPending(requestPending),
		.shotActive(shotActive), .lockOutState(lockOutState), .irq(irq),
		.sequenceReclaimActive(sequenceReclaimActive)
	);
	brs_breaker_model #(.DELAY(4)) i_brk (
		.sys_clk(sys_clk), .rstn(rstn), .closeCmd(closeCmd),
		.openCmd(openCmd), .protOpen(|reqTrip), .refuse(refuse),
		.manualClose(manualClose), .brkOpen(brkOpen),
		.brkClosed(brkClosed), .objAckOk(objAckOk), .objAckFail(objAckFail)
	);

	// Clock generation
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ==================================================================
	// Helpers
	function automatic logic sel(input int w);
		case (w)
			W_CLS: return closeCmd;
			W_OPN: return openCmd;
			W_LCK: return lockOutState;
			W_SEQ: return sequenceActive;
			W_BOP: return brkOpen;
			W_BCL: return brkClosed;
			default: return sequenceReclaimActive;
		endcase
	endfunction : sel

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic check_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : check_val

	// Cycle count must lie in a small window around lo
	task automatic check_span(input string nm, input int c, input int lo);
		checks_done++;
		if (c < lo - 2 || c > lo + 6) begin
			fail_count++;
			$display("unexpected %s: expected %0d, seen %0d", nm, lo, c);
		end
	endtask : check_span

	// Bounded wait on an output, counted in cycles
	task automatic wait_for(input int w, input logic v, input int lim,
		output int c);
		c = 0;
		while (sel(w) !== v && c < lim) begin
			@(negedge sys_clk);
			c++;
		end
		check_val("waitedSignal", 32'(v), 32'(sel(w)));
		if (sel(w) !== v)
			finish_test();
	endtask : wait_for

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		d = regRdData;
	endtask : reg_read

	// Trip, open, release, timed dead time, close
	task automatic run_shot(input logic [4:0] req, input int dead);
		int c;
		@(posedge sys_clk);
		reqTrip <= req;
		wait_for(W_BOP, 1'b1, 20, c);
		@(posedge sys_clk);
		reqTrip <= '0;
		wait_for(W_CLS, 1'b1, dead + 20, c); // close via object
		check_span("deadTime", c, dead);
		wait_for(W_CLS, 1'b0, 20, c); // close dropped
	endtask : run_shot

	task automatic clear_lock();
		@(posedge sys_clk);
		reqTrip     <= '0;
		critReq     <= 1'b0;
		refuse      <= 1'b0;
		lockResetIn <= 1'b1;
		wait_for(W_LCK, 1'b0, 10, n); // reset input
		@(posedge sys_clk);
		lockResetIn <= 1'b0;
		manualClose <= 1'b1;
		@(posedge sys_clk);
		manualClose <= 1'b0;
		wait_for(W_BCL, 1'b1, 6, n);
	endtask : clear_lock

	// ==================================================================
	// Scenarios
	task automatic t_regs();
		logic [7:0]  adr [8] = '{A_CTRL, A_SHOTEN, A_SHREC, A_SQREC,
			A_STATUS, A_DEAD0, 8'h24, 8'h48};
		logic [31:0] exv [8] = '{32'h0000_0003, 32'h0000_03FF,
			32'h0000_001E, 32'h0000_001E, 32'h0000_0001, 32'h0000_0014,
			32'h0000_0028, 32'h0000_0000};
		for (int i = 0; i < 8; i++) begin
			reg_read(adr[i], rd);
			check_val("regReset", exv[i], rd);
		end
		reg_write(8'h60, 32'hFFFF_FFFF);
		reg_read(8'h60, rd);
		check_val("unmapped", 32'h0000_0000, rd);
		$display("test regs done");
	endtask : t_regs

	task automatic t_one_shot();
		run_shot(5'h02, T_FAST);
		check_val("pending", 32'h0000_0002, 32'(requestPending));
		check_val("shot", 32'h0000_0001, 32'(shotActive));
		wait_for(W_SEQ, 1'b0, T_SHR + 10, n);
		check_span("shotReclaim", n, T_SHR);
		check_val("seqRecl", 32'h1, 32'(sequenceReclaimActive));
		check_val("pendOff", 32'h0, 32'(requestPending));
		wait_for(W_SRA, 1'b0, T_SQR + 10, n);
		check_span("seqReclaim", n, T_SQR);
		reg_read(A_STATUS, rd);
		check_val("ready", 32'h0000_0001, rd);
		$display("test one shot done");
	endtask : t_one_shot

	task automatic t_prio_zero();
		reg_write(A_SHREC, 32'h0000_0000);
		reg_write(A_SQREC, 32'h0000_0000);
		reg_write(8'h30, 32'(T_ALT));
		@(posedge sys_clk);
		reqTrip <= 5'h14;
		wait_for(W_SEQ, 1'b1, 5, n); // no start timer
		check_val("priority", 32'h0000_0004, 32'(requestPending));
		run_shot(5'h14, T_ALT); // own dead time
		wait_for(W_SEQ, 1'b0, 4, n); // zero reclaim
		check_val("noSeqRecl", 32'h0, 32'(sequenceReclaimActive));
		reg_write(A_SHREC, 32'(T_SHR));
		reg_write(A_SQREC, 32'(T_SQR));
		$display("test priority done");
	endtask : t_prio_zero

	task automatic t_two_fail();
		run_shot(5'h02, T_FAST);
		run_shot(5'h02, T_SLOW);
		check_val("shotTwo", 32'h0000_0002, 32'(shotActive));
		@(posedge sys_clk);
		reqTrip <= 5'h02;
		wait_for(W_OPN, 1'b1, 6, n); // final trip
		check_val("seqOff", 32'h0, 32'(sequenceActive));
		check_val("shotOff", 32'h0, 32'(shotActive));
		wait_for(W_LCK, 1'b1, 20, n); // lock after final
		@(posedge sys_clk);
		reqTrip <= 5'h01;
		repeat (8) @(negedge sys_clk);
		check_val("ignored", 32'h0, 32'(sequenceActive));
		clear_lock();
		$display("test two shots done");
	endtask : t_two_fail

	task automatic t_seq_final();
		run_shot(5'h01, T_FAST);
		wait_for(W_SEQ, 1'b0, T_SHR + 10, n);
		@(posedge sys_clk);
		reqTrip <= 5'h01;
		wait_for(W_OPN, 1'b1, 6, n); // final in reclaim
		wait_for(W_LCK, 1'b1, 20, n);
		clear_lock();
		$display("test sequence reclaim done");
	endtask : t_seq_final

	// Fault in sequence reclaim with final trip disabled restarts
	task automatic t_seq_restart();
		reg_write(A_CTRL, 32'h0000_0001);
		run_shot(5'h01, T_FAST);
		wait_for(W_SEQ, 1'b0, T_SHR + 10, n);
		@(posedge sys_clk);
		reqTrip <= 5'h01;
		wait_for(W_SEQ, 1'b1, 6, n);
		check_val("restartShot", 32'h1, 32'(shotActive));
		check_val("noFinal", 32'h0, 32'(openCmd));
		run_shot(5'h01, T_FAST);
		wait_for(W_SEQ, 1'b0, T_SHR + 10, n);
		wait_for(W_SRA, 1'b0, T_SQR + 10, n);
		reg_write(A_CTRL, 32'h0000_0003);
		$display("test sequence restart done");
	endtask : t_seq_restart

	task automatic t_fail_close();
		@(posedge sys_clk);
		refuse <= 1'b1;
		run_shot(5'h01, T_FAST);
		wait_for(W_LCK, 1'b1, 6, n); // failure locks
		@(posedge sys_clk);
		refuse      <= 1'b0;
		manualClose <= 1'b1;
		@(posedge sys_clk);
		manualClose <= 1'b0;
		wait_for(W_LCK, 1'b0, 10, n); // closed by hand
		$display("test close failure done");
	endtask : t_fail_close

	task automatic t_crit_irq();
		reg_write(A_IRQST, 32'h0000_003F);
		reg_write(A_IRQMSK, 32'h0000_0000);
		@(posedge sys_clk);
		refuse  <= 1'b1;
		critReq <= 1'b1;
		wait_for(W_OPN, 1'b1, 6, n); // critical halts
		wait_for(W_LCK, 1'b1, 20, n); // blocked open locks
		reg_write(A_IRQMSK, 32'h0000_0004);
		reg_read(A_IRQST, rd);
		check_val("irqStatus", 32'h0000_001C, rd);
		check_val("irqOn", 32'h1, 32'(irq));
		reg_write(A_IRQST, 32'h0000_0004);
		reg_read(A_IRQST, rd);
		check_val("irqCleared", 32'h0000_0018, rd);
		check_val("irqOff", 32'h0, 32'(irq));
		clear_lock();
		$display("test critical done");
	endtask : t_crit_irq

	// ==================================================================
	// Main sequence
	initial begin
		{rstn, regWr, regRd, critReq, lockResetIn} = '0;
		{refuse, manualClose} = '0;
		regAddr     = '0;
		regWrData   = '0;
		reqTrip     = '0;
		fail_count  = 0;
		checks_done = 0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_one_shot();
		t_prio_zero();
		t_two_fail();
		t_seq_final();
		t_seq_restart();
		t_fail_close();
		t_crit_irq();
		finish_test();
	end
endmodule : tb_top
